// [logic/mmv_decode.sv]
// Combinational address space decoder
`timescale 1ns/100ps
module mmv_decode
	import mmv_pkg::*;
(
	mmv_if.dec              bus,
	input  wire logic [1:0] variant
);
	logic [15:0] flash_end;
	logic [5:0]  blk_last;
	always_comb
	begin
		case (variant)
			MMV_VAR_SMALL:
			begin
				flash_end = MMV_FLASH_END_SMALL;
				blk_last  = MMV_BLK_LAST_SMALL;
			end
			MMV_VAR_MEDIUM:
			begin
				flash_end = MMV_FLASH_END_MEDIUM;
				blk_last  = MMV_BLK_LAST_MEDIUM;
			end
			default:
			begin
				flash_end = MMV_FLASH_END_LARGE;
				blk_last  = MMV_BLK_LAST_LARGE;
			end
		endcase
	end
	assign bus.block       = bus.addr[15:MMV_BLK_LSB];
	assign bus.flash_hit   = (bus.addr <= flash_end);
	assign bus.valid_flash = (bus.block <= blk_last);
	assign bus.vec_hit     = (bus.addr <= MMV_VEC_END);
	assign bus.sfr_hit     = (bus.addr >= MMV_SFR_BASE);
	assign bus.boot0_hit   = (bus.addr <= MMV_BOOT0_END);
endmodule : mmv_decode

// [logic/mmv_if.sv]
// Bundle between the vector sequencer and the address decoder
`timescale 1ns/100ps
interface mmv_if;
	logic [15:0] addr;
	logic        flash_hit;
	logic        vec_hit;
	logic        sfr_hit;
	logic        valid_flash;
	logic [5:0]  block;
	logic        boot0_hit;
	modport dec (input addr, output flash_hit, vec_hit, sfr_hit, valid_flash, block, boot0_hit);
	modport top (output addr, input flash_hit, vec_hit, sfr_hit, valid_flash, block, boot0_hit);
endinterface : mmv_if

// [logic/mmv_pkg.sv]
// Constants and types for the memory map and vector decoder
package mmv_pkg;
	localparam logic [7:0]  MMV_MEM_SIZE_RST     = 8'hcf;
	localparam logic [7:0]  MMV_XRAM_SIZE_RST    = 8'h0c;
	localparam logic [7:0]  MMV_MEM_SIZE_32K     = 8'hc8;
	localparam logic [7:0]  MMV_MEM_SIZE_48K     = 8'hcc;
	localparam logic [7:0]  MMV_MEM_SIZE_60K     = 8'hcf;
	localparam logic [7:0]  MMV_XRAM_SIZE_32K    = 8'h0a;
	localparam logic [7:0]  MMV_XRAM_SIZE_BIG    = 8'h08;
	localparam logic [5:0]  MMV_BLK_LAST_SMALL   = 6'h1f;
	localparam logic [5:0]  MMV_BLK_LAST_MEDIUM  = 6'h2f;
	localparam logic [5:0]  MMV_BLK_LAST_LARGE   = 6'h3b;
	localparam logic [15:0] MMV_FLASH_END_SMALL  = 16'h7fff;
	localparam logic [15:0] MMV_FLASH_END_MEDIUM = 16'hbfff;
	localparam logic [15:0] MMV_FLASH_END_LARGE  = 16'hefff;
	localparam int          MMV_BLK_LSB          = 10;
	localparam logic [15:0] MMV_VEC_END          = 16'h003f;
	localparam logic [15:0] MMV_RESET_VEC        = 16'h0000;
	localparam logic [15:0] MMV_SFR_BASE         = 16'hff00;
	localparam logic [15:0] MMV_BOOT0_END        = 16'h0fff;
	localparam logic [15:0] MMV_LVI_VEC          = 16'h0004;
	localparam logic [15:0] MMV_EXTERNAL_INTERRUPT_0_VEC        = 16'h0006;
	localparam logic [15:0] MMV_CANERR_VEC       = 16'h0012;
	localparam logic [15:0] MMV_BRK_VEC          = 16'h003e;
	localparam logic [4:0]  MMV_SRC_BRK          = 5'h1f;
	typedef enum logic [1:0] {
		MMV_VAR_SMALL  = 2'h0,
		MMV_VAR_MEDIUM = 2'h1,
		MMV_VAR_LARGE  = 2'h2
	} mmv_variant_t;
	typedef enum logic [3:0] {
		MMV_IDLE = 4'h1,
		MMV_LOW  = 4'h2,
		MMV_HIGH = 4'h4,
		MMV_DONE = 4'h8
	} mmv_state_t;
endpackage : mmv_pkg

// [logic/mmv_top.sv]
// Memory map decoder with reset and interrupt vector fetch
`timescale 1ns/100ps
module mmv_top
	import mmv_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic [1:0]  variant,
	input  wire logic        boot0_protect,
	input  wire logic        cpu_req,
	input  wire logic        cpu_we,
	input  wire logic [15:0] cpu_addr,
	input  wire logic [7:0]  cpu_wdata,
	input  wire logic        size_we,
	input  wire logic        size_sel,
	input  wire logic        irq_ack,
	input  wire logic [4:0]  irq_src,
	input  wire logic [7:0]  flash_rdata,
	input  wire logic [15:0] program_counter,
	output logic             mem_req,
	output logic             mem_we,
	output logic [15:0]      mem_addr,
	output logic             flash_sel,
	output logic             sfr_sel,
	output logic             vec_sel,
	output logic [5:0]       flash_block,
	output logic             block_invalid,
	output logic             write_refused,
	output logic             busy,
	output logic             pc_load,
	output logic [15:0]      pc_value,
	output logic [7:0]       memory_size_select,
	output logic [7:0]       expansion_ram_size_select
);
	mmv_if bus ();
	mmv_state_t  state_reg, state_next;
	logic [15:0] vaddr_reg, vaddr_next;
	logic [7:0]  low_reg, low_next;
	logic [15:0] pc_reg, pc_next;
	logic        load_reg, load_next;
	logic [7:0]  ims_reg, ims_next;
	logic [7:0]  ixs_reg, ixs_next;
	logic        seq_fetch;
	logic        prot_hit;
	mmv_decode u_dec (
		.bus     (bus),
		.variant (variant)
	);
	// Sequencer owns the address bus while fetching a vector
	assign seq_fetch = (state_reg == MMV_LOW) || (state_reg == MMV_HIGH);
	assign bus.addr  = seq_fetch ? vaddr_reg : (cpu_req ? cpu_addr : program_counter);
	assign prot_hit  = cpu_req && cpu_we && boot0_protect && bus.boot0_hit && !seq_fetch;
	assign mem_req       = seq_fetch || (cpu_req && !prot_hit);
	assign mem_we        = cpu_req && cpu_we && !prot_hit && !seq_fetch;
	assign write_refused = prot_hit;
	assign mem_addr      = bus.addr;
	assign flash_sel     = bus.flash_hit && bus.valid_flash;
	assign sfr_sel       = bus.sfr_hit;
	assign vec_sel       = bus.vec_hit;
	assign flash_block   = bus.block;
	// Any block past the variant's last one, peripheral area included
	assign block_invalid = !bus.valid_flash;
	assign busy          = (state_reg != MMV_IDLE);
	assign pc_load       = load_reg;
	assign pc_value      = pc_reg;
	assign memory_size_select        = ims_reg;
	assign expansion_ram_size_select = ixs_reg;
	// Size selects are plain storage; the variant input steers decode
	always_comb
	begin
		ims_next = ims_reg;
		ixs_next = ixs_reg;
		if (size_we && !size_sel)
			ims_next = cpu_wdata;
		else if (size_we && size_sel)
			ixs_next = cpu_wdata;
	end
	always_comb
	begin
		state_next = state_reg;
		vaddr_next = vaddr_reg;
		low_next   = low_reg;
		pc_next    = pc_reg;
		load_next  = 1'b0;
		case (state_reg)
			MMV_IDLE:
			begin
				if (irq_ack)
				begin
					vaddr_next = {10'h000, irq_src, 1'b0};
					state_next = MMV_LOW;
				end
			end
			MMV_LOW:
			begin
				low_next   = flash_rdata;
				vaddr_next = vaddr_reg | 16'h0001;
				state_next = MMV_HIGH;
			end
			MMV_HIGH:
			begin
				pc_next    = {flash_rdata, low_reg};
				load_next  = 1'b1;
				state_next = MMV_DONE;
			end
			default:
			begin
				state_next = MMV_IDLE;
			end
		endcase
	end
	// Out of reset the first fetch is the reset vector, same for every cause
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state_reg <= MMV_LOW;
			vaddr_reg <= MMV_RESET_VEC;
			low_reg   <= 8'h00;
			pc_reg    <= 16'h0000;
			load_reg  <= 1'b0;
			ims_reg   <= MMV_MEM_SIZE_RST;
			ixs_reg   <= MMV_XRAM_SIZE_RST;
		end
		else
		begin
			state_reg <= state_next;
			vaddr_reg <= vaddr_next;
			low_reg   <= low_next;
			pc_reg    <= pc_next;
			load_reg  <= load_next;
			ims_reg   <= ims_next;
			ixs_reg   <= ixs_next;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	// Reset must be watched while it is held, so this one ignores the default
	reset_vec_a: assert property (disable iff (1'b0)
		!rstn |-> (mem_addr == MMV_RESET_VEC) && busy)
		else $error("reset vector not on bus");
	// Vector sequencer
	vec_low_high_a: assert property ((state_reg == MMV_LOW) |=>
		(state_reg == MMV_HIGH) && (mem_addr == ($past(mem_addr) | 16'h0001)) ##1 pc_load)
		else $error("vector fetch not low then high");
	vec_addr_a: assert property ((state_reg == MMV_IDLE && irq_ack) |=>
		(mem_addr == {10'h000, $past(irq_src), 1'b0}) && mem_req)
		else $error("wrong vector address");
	pc_value_a: assert property (pc_load |->
		pc_value == {$past(flash_rdata), $past(flash_rdata, 2)})
		else $error("pc value not assembled");
	// A late acknowledge would tear the word being assembled
	ack_busy_a: assert property (busy && irq_ack |=> state_reg != MMV_LOW)
		else $error("acknowledge taken while busy");
	load_pulse_a: assert property (pc_load |=> !pc_load)
		else $error("load pulse too long");
	pc_hold_a: assert property (!pc_load |-> $stable(pc_value))
		else $error("pc value moved without load");
	fetch_owner_a: assert property (state_reg == MMV_LOW || state_reg == MMV_HIGH |->
		mem_req && !mem_we && !write_refused)
		else $error("cpu reached bus during vector fetch");
	state_onehot_a: assert property ($onehot(state_reg))
		else $error("sequencer state not one-hot");
	// Address decode; variant strap steers it, size selects do not
	block_num_a: assert property (flash_block == mem_addr[15:10])
		else $error("block number mismatch");
	flash_end_a: assert property (variant == MMV_VAR_SMALL
		&& mem_addr > MMV_FLASH_END_SMALL |-> !flash_sel)
		else $error("flash selected past end");
	flash_medium_a: assert property (variant == MMV_VAR_MEDIUM |->
		flash_sel == (mem_addr <= MMV_FLASH_END_MEDIUM))
		else $error("medium flash range wrong");
	block_valid_a: assert property (variant == MMV_VAR_LARGE
		&& mem_addr[15:10] == MMV_BLK_LAST_LARGE |-> flash_sel)
		else $error("last valid block not selected");
	blk_small_a: assert property (variant == MMV_VAR_SMALL |->
		block_invalid == (flash_block > MMV_BLK_LAST_SMALL))
		else $error("small block range wrong");
	blk_medium_a: assert property (variant == MMV_VAR_MEDIUM |->
		block_invalid == (flash_block > MMV_BLK_LAST_MEDIUM))
		else $error("medium block range wrong");
	sfr_area_a: assert property (sfr_sel == (mem_addr[15:8] == 8'hff))
		else $error("peripheral area decode wrong");
	sel_split_a: assert property (!(flash_sel && sfr_sel))
		else $error("flash and peripheral both selected");
	fetch_src_a: assert property (!busy && !cpu_req |-> mem_addr == program_counter)
		else $error("fetch not from program counter");
	vec_area_a: assert property (vec_sel == (mem_addr < 16'h0040))
		else $error("vector area decode wrong");
	// Refusal and size storage
	boot_prot_a: assert property (cpu_req && cpu_we && boot0_protect && !busy
		&& cpu_addr < 16'h1000 |-> !mem_we && write_refused)
		else $error("protected write passed");
	refuse_only_a: assert property (write_refused |->
		cpu_req && cpu_we && boot0_protect)
		else $error("write refused without cause");
	size_hold_a: assert property (!size_we |=> $stable(memory_size_select)
		&& $stable(expansion_ram_size_select))
		else $error("size select changed");
	size_load_a: assert property (size_we && !size_sel |=>
		memory_size_select == $past(cpu_wdata))
		else $error("size select write lost");
	ack_cover_c: cover property (state_reg == MMV_IDLE && irq_ack ##3 pc_load);
	brk_cover_c: cover property (irq_ack && irq_src == MMV_SRC_BRK && !busy);
	refuse_cover_c: cover property (write_refused);
	size_cover_c: cover property (size_we && cpu_wdata == MMV_MEM_SIZE_32K);
	inval_cover_c: cover property (cpu_req && block_invalid);
endmodule : mmv_top

// [tb/mmv_flash_model.sv]
// Flash array stand-in answering vector and data reads
`timescale 1ns/100ps
module mmv_flash_model
	import mmv_pkg::*;
(
	input  wire logic        mem_req,
	input  wire logic [15:0] mem_addr,
	output logic [7:0]       flash_rdata
);
	// Data during a request mixes both address bytes so a swapped byte order shows
	always_comb
	begin
		if (mem_req)
			flash_rdata = mem_addr[7:0] ^ mem_addr[15:8] ^ 8'ha5;
		else
			flash_rdata = ~(mem_addr[7:0] ^ 8'ha5);
	end
endmodule : mmv_flash_model

// [tb/testbench.sv]
// Self-checking bench for the memory map and vector decoder
`timescale 1ns/100ps
module testbench
	import mmv_pkg::*;
;
	logic        clk, rstn, boot0_protect, cpu_req, cpu_we, size_we, size_sel, irq_ack;
	logic        mem_req, mem_we, flash_sel, sfr_sel, vec_sel, block_invalid;
	logic        write_refused, busy, pc_load;
	logic [1:0]  variant;
	logic [4:0]  irq_src;
	logic [5:0]  flash_block;
	logic [7:0]  cpu_wdata, flash_rdata, mss, xss;
	logic [15:0] cpu_addr, program_counter, mem_addr, pc_value;
	int          n_errors, total_checks;

	mmv_top i_dut (.clk, .rstn, .variant, .boot0_protect, .cpu_req, .cpu_we, .cpu_addr,
		.cpu_wdata, .size_we, .size_sel, .irq_ack, .irq_src, .flash_rdata, .program_counter,
		.mem_req, .mem_we, .mem_addr, .flash_sel, .sfr_sel, .vec_sel, .flash_block,
		.block_invalid, .write_refused, .busy, .pc_load, .pc_value,
		.memory_size_select(mss), .expansion_ram_size_select(xss));
	mmv_flash_model i_flash (.mem_req, .mem_addr, .flash_rdata);

	task automatic report_and_stop;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : report_and_stop

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// Byte the flash stand-in holds at an address
	function automatic logic [7:0] fbyte(input logic [15:0] a);
		return a[7:0] ^ a[15:8] ^ 8'ha5;
	endfunction : fbyte

	// Vector word: even address gives the low byte, odd the high
	function automatic logic [15:0] vword(input logic [15:0] a);
		return {fbyte(a | 16'h0001), fbyte(a & 16'hfffe)};
	endfunction : vword

	task automatic tick;
		@(posedge clk);
		#1;
	endtask : tick

	// Starts as reset lets go; vector bytes come at the next two edges
	task automatic t_reset;
		chk("mem_size", {8'h00, MMV_MEM_SIZE_RST}, {8'h00, mss});
		chk("xram_size", {8'h00, MMV_XRAM_SIZE_RST}, {8'h00, xss});
		chk("rst_lo_addr", MMV_RESET_VEC, mem_addr);
		tick();
		chk("rst_hi_addr", MMV_RESET_VEC + 16'h0001, mem_addr);
		tick();
		chk("pc_load", 16'h0001, {15'h0, pc_load});
		chk("reset_pc", vword(MMV_RESET_VEC), pc_value);
		tick();
		chk("pc_load_end", 16'h0000, {15'h0, pc_load});
		chk("busy_end", 16'h0000, {15'h0, busy});
	endtask : t_reset

	task automatic t_vector(input logic [4:0] src, input logic [15:0] vec);
		irq_src = src;
		irq_ack = 1'b1;
		tick();
		irq_src = ~src; // Held ack while busy must be ignored
		chk("vec_lo_addr", vec, mem_addr);
		chk("vec_busy", 16'h0001, {15'h0, busy});
		tick();
		irq_ack = 1'b0;
		chk("vec_hi_addr", vec + 16'h0001, mem_addr);
		tick();
		chk("vec_load", 16'h0001, {15'h0, pc_load});
		chk("vec_pc", vword(vec), pc_value);
		tick();
		chk("vec_idle", 16'h0000, {15'h0, busy});
		chk("vec_load_end", 16'h0000, {15'h0, pc_load});
	endtask : t_vector

	task automatic t_decode(input logic [1:0] v, input logic [15:0] a, input logic [3:0] e);
		variant = v;
		cpu_addr = a;
		cpu_req = 1'b1;
		#4;
		chk("mem_addr", a, mem_addr);
		chk("flash_block", {10'h0, a[15:10]}, {10'h0, flash_block});
		chk("flash_sel", {15'h0, e[3]}, {15'h0, flash_sel});
		chk("vec_sel", {15'h0, e[2]}, {15'h0, vec_sel});
		chk("sfr_sel", {15'h0, e[1]}, {15'h0, sfr_sel});
		chk("block_invalid", {15'h0, e[0]}, {15'h0, block_invalid});
		tick();
	endtask : t_decode

	task automatic t_write(input logic p, input logic [15:0] a, input logic refused);
		boot0_protect = p;
		cpu_addr = a;
		cpu_req = 1'b1;
		cpu_we = 1'b1;
		#4;
		chk("write_refused", {15'h0, refused}, {15'h0, write_refused});
		chk("mem_we", {15'h0, !refused}, {15'h0, mem_we});
		tick();
	endtask : t_write

	task automatic t_size;
		cpu_req = 1'b0;
		cpu_we = 1'b0;
		size_we = 1'b1;
		cpu_wdata = MMV_MEM_SIZE_32K;
		tick();
		size_sel = 1'b1;
		cpu_wdata = MMV_XRAM_SIZE_32K;
		tick();
		size_we = 1'b0;
		program_counter = 16'h1234;
		#4;
		chk("mem_size", {8'h00, MMV_MEM_SIZE_32K}, {8'h00, mss});
		chk("xram_size", {8'h00, MMV_XRAM_SIZE_32K}, {8'h00, xss});
		chk("fetch_addr", 16'h1234, mem_addr);
	endtask : t_size

	// Second reset mid-run: software size values must fall back
	task automatic t_midreset;
		tick();
		rstn = 1'b0;
		#4;
		chk("mem_size_rst", {8'h00, MMV_MEM_SIZE_RST}, {8'h00, mss});
		chk("rst_addr", MMV_RESET_VEC, mem_addr);
		tick();
		tick();
		rstn = 1'b1;
		t_reset();
	endtask : t_midreset

	initial
	begin
		clk = 1'b0;
		forever
			#5 clk = ~clk;
	end

	// Whole run needs well under 200 cycles
	initial
	begin
		#20000;
		n_errors++;
		report_and_stop();
	end

	initial
	begin
		{rstn, boot0_protect, cpu_req, cpu_we, size_we, size_sel, irq_ack} = 7'h00;
		{variant, irq_src, cpu_wdata, cpu_addr, program_counter} = 47'h0;
		repeat (2)
			@(posedge clk);
		#1;
		rstn = 1'b1;
		t_reset();
		t_vector(5'h02, MMV_LVI_VEC);
		t_vector(5'h03, MMV_EXTERNAL_INTERRUPT_0_VEC);
		t_vector(5'h09, MMV_CANERR_VEC);
		t_vector(MMV_SRC_BRK, MMV_BRK_VEC);
		t_vector(5'h00, MMV_RESET_VEC);
		// Decode probes only read; no write lands in the peripheral area
		t_decode(2'h0, 16'h0000, 4'hc);
		t_decode(2'h0, 16'h003f, 4'hc);
		t_decode(2'h0, 16'h0040, 4'h8);
		t_decode(2'h0, 16'h7fff, 4'h8);
		t_decode(2'h0, 16'h8000, 4'h1);
		t_decode(2'h1, 16'hbfff, 4'h8);
		t_decode(2'h1, 16'hc000, 4'h1);
		t_decode(2'h2, 16'hefff, 4'h8);
		t_decode(2'h2, 16'hf000, 4'h1);
		t_decode(2'h2, 16'hfeff, 4'h1);
		t_decode(2'h2, 16'hff00, 4'h3);
		t_decode(2'h3, 16'hffff, 4'h3);
		t_write(1'b1, 16'h0fff, 1'b1);
		t_write(1'b1, 16'h1000, 1'b0);
		t_write(1'b0, 16'h0000, 1'b0);
		t_write(1'b0, 16'h0080, 1'b0);
		t_write(1'b0, 16'h1080, 1'b0);
		t_write(1'b1, 16'h0084, 1'b1);
		t_size();
		t_midreset();
		report_and_stop();
	end
endmodule : testbench
